// ===== sqw_pkg.sv
// Shared constants, types and opcodes for the serial register write slave.
`default_nettype none

package sqw_pkg;

  // ---------------------------------------------------------------
  // Command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_DUAL_DATA_WRITE = 8'h32;
  localparam logic [7:0] OPC_QUAD_DATA_WRITE = 8'h62;
  localparam logic [7:0] OPC_DUAL_ADDR_DATA_WRITE = 8'hb2;
  localparam logic [7:0] OPC_QUAD_ADDR_DATA_WRITE = 8'he2;

  // ---------------------------------------------------------------
  // Field sizes and positions
  // ---------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h10;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam int DWORD_W = 12;
  localparam int DWORD_LSB = 2;
  localparam int DWORD_MSB = 13;
  localparam int BURST_LSB = 14;
  localparam int BURST_MSB = 15;

  // ---------------------------------------------------------------
  // Lane widths (bits taken per serial clock)
  // ---------------------------------------------------------------
  localparam logic [2:0] LANES_ONE = 3'h1;
  localparam logic [2:0] LANES_TWO = 3'h2;
  localparam logic [2:0] LANES_FOUR = 3'h4;

  // ---------------------------------------------------------------
  // Burst address modes
  // ---------------------------------------------------------------
  localparam logic [1:0] BURST_INC = 2'h1;
  localparam logic [1:0] BURST_DEC = 2'h2;
  localparam logic [11:0] DWORD_STEP = 12'h001;

  // ---------------------------------------------------------------
  // Status FIFO read addresses (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] RX_STATUS_ADDR = 16'h0040;
  localparam logic [15:0] RX_STATUS_PEEK_ADDR = 16'h0044;
  localparam logic [15:0] TX_STATUS_ADDR = 16'h0048;
  localparam logic [15:0] TX_STATUS_PEEK_ADDR = 16'h004c;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_IGNORE} link_state_t;

  typedef struct packed {
    logic [11:0] dword_addr;
    logic [31:0] data;
  } wr_req_t;

endpackage : sqw_pkg

`default_nettype wire

// ===== sqw_sync2.sv
// Two flip-flop level synchroniser.
`default_nettype none

module sqw_sync2 (
  // Destination clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Level to carry across
  input wire logic i_level,
  output logic o_level
);

  logic meta;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta <= i_level;
      o_level <= meta;
    end
  end

endmodule : sqw_sync2

`default_nettype wire

// ===== serial_quad_register_write_slave.sv
// Write-command decoder of the serial register slave port, with word hand-over to the system clock.
`default_nettype none

module serial_quad_register_write_slave (
  // System clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Serial link pins
  input wire logic i_serial_clk,
  input wire logic i_serial_select_n,
  input wire logic [3:0] i_serial_lanes,
  // Protocol mode strap
  input wire logic i_quad_lane_protocol,
  // Register write port
  output logic o_wr_strobe,
  output logic [11:0] o_wr_dword_addr,
  output logic [31:0] o_wr_data,
  // Frame status
  output logic o_frame_active,
  // Status FIFO read decode
  input wire logic i_rd_strobe,
  input wire logic [15:0] i_rd_addr,
  output logic o_rx_status_pop,
  output logic o_tx_status_pop
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Shift the sampled lanes into the low end of the assembly register.
  function automatic logic [31:0] shift_in(input logic [31:0] cur, input logic [2:0] width,
                                           input logic [3:0] lanes);
    logic [31:0] res;
    res = {cur[27:0], lanes[3:0]};
    if (width == sqw_pkg::LANES_ONE) begin
      res = {cur[30:0], lanes[0]};
    end else if (width == sqw_pkg::LANES_TWO) begin
      res = {cur[29:0], lanes[1:0]};
    end
    return res;
  endfunction : shift_in

  // The first byte on the wire is the least significant byte of the word.
  function automatic logic [31:0] byte_swap(input logic [31:0] stream);
    return {stream[7:0], stream[15:8], stream[23:16], stream[31:24]};
  endfunction : byte_swap

  // ---------------------------------------------------------------
  // Link domain reset and mode
  // ---------------------------------------------------------------

  // Select high holds the command logic in reset, so a partial word simply vanishes.
  wire link_rst_n;
  assign link_rst_n = i_arst_n & ~i_serial_select_n;

  logic quad_mode;

  // The mode strap is static in use; two serial clocks of latency after a change are harmless.
  sqw_sync2 u_mode_sync (
    .i_clk(i_serial_clk),
    .i_arst_n(i_arst_n),
    .i_level(i_quad_lane_protocol),
    .o_level(quad_mode)
  );

  // ---------------------------------------------------------------
  // Link domain command state
  // ---------------------------------------------------------------
  sqw_pkg::link_state_t state;
  logic [5:0] bit_cnt;
  logic [31:0] shift;
  logic [2:0] addr_width;
  logic [2:0] data_width;
  logic [1:0] burst;
  logic [11:0] dword;

  // Width of the current phase: opcode is serial unless quad-lane protocol is active.
  wire [2:0] op_width;
  wire [2:0] cur_width;
  assign op_width = quad_mode ? sqw_pkg::LANES_FOUR : sqw_pkg::LANES_ONE;
  assign cur_width = (state == sqw_pkg::ST_OPCODE) ? op_width :
                     (state == sqw_pkg::ST_ADDR) ? addr_width : data_width;

  // Lanes are sampled on the rising serial clock edge.
  wire [31:0] next_shift;
  wire [5:0] next_cnt;
  assign next_shift = shift_in(shift, cur_width, i_serial_lanes);
  assign next_cnt = bit_cnt + {3'h0, cur_width};

  // Opcode decode on the byte just completed.
  wire [7:0] opc;
  wire is_plain;
  wire is_dd;
  wire is_qd;
  wire is_dad;
  wire is_qad;
  wire opc_accept;
  assign opc = next_shift[7:0];
  assign is_plain = (opc == sqw_pkg::OPC_WRITE);
  assign is_dd = (opc == sqw_pkg::OPC_DUAL_DATA_WRITE);
  assign is_qd = (opc == sqw_pkg::OPC_QUAD_DATA_WRITE);
  assign is_dad = (opc == sqw_pkg::OPC_DUAL_ADDR_DATA_WRITE);
  assign is_qad = (opc == sqw_pkg::OPC_QUAD_ADDR_DATA_WRITE);
  assign opc_accept = is_plain | (~quad_mode & (is_dd | is_qd | is_dad | is_qad));

  // Lane widths that the opcode sets for the address and data phases.
  wire [2:0] next_addr_width;
  wire [2:0] next_data_width;
  assign next_addr_width = (quad_mode | is_qad) ? sqw_pkg::LANES_FOUR :
                           is_dad ? sqw_pkg::LANES_TWO : sqw_pkg::LANES_ONE;
  assign next_data_width = (quad_mode | is_qd | is_qad) ? sqw_pkg::LANES_FOUR :
                           (is_dd | is_dad) ? sqw_pkg::LANES_TWO : sqw_pkg::LANES_ONE;

  // Phase completion strobes.
  wire opc_done;
  wire addr_done;
  wire word_done;
  assign opc_done = (state == sqw_pkg::ST_OPCODE) && (next_cnt == sqw_pkg::OPC_BITS);
  assign addr_done = (state == sqw_pkg::ST_ADDR) && (next_cnt == sqw_pkg::ADDR_BITS);
  assign word_done = (state == sqw_pkg::ST_DATA) && (next_cnt == sqw_pkg::WORD_BITS);

  // Address step for the next word of a burst.
  wire [11:0] next_dword;
  assign next_dword = (burst == sqw_pkg::BURST_INC) ? dword + sqw_pkg::DWORD_STEP :
                      (burst == sqw_pkg::BURST_DEC) ? dword - sqw_pkg::DWORD_STEP : dword;

  // Phase sequencing; once in the ignore state only a select release or the system reset gets out.
  always_ff @(posedge i_serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= sqw_pkg::ST_OPCODE;
    end else begin
      unique case (state)
        sqw_pkg::ST_OPCODE: begin
          if (opc_done) begin
            state <= opc_accept ? sqw_pkg::ST_ADDR : sqw_pkg::ST_IGNORE;
          end
        end
        sqw_pkg::ST_ADDR: begin
          if (addr_done) begin
            state <= sqw_pkg::ST_DATA;
          end
        end
        sqw_pkg::ST_DATA: begin
          state <= sqw_pkg::ST_DATA;
        end
        sqw_pkg::ST_IGNORE: begin
          state <= sqw_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // Bit counter restarts at each phase boundary and after every full word.
  always_ff @(posedge i_serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= sqw_pkg::CNT_ZERO;
    end else if (opc_done | addr_done | word_done | (state == sqw_pkg::ST_IGNORE)) begin
      bit_cnt <= sqw_pkg::CNT_ZERO;
    end else begin
      bit_cnt <= next_cnt;
    end
  end

  // Assembly register collects opcode, address and data in turn.
  always_ff @(posedge i_serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift <= '0;
    end else begin
      shift <= next_shift;
    end
  end

  // Lane widths are fixed for the rest of the command once the opcode is known.
  always_ff @(posedge i_serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      addr_width <= sqw_pkg::LANES_ONE;
      data_width <= sqw_pkg::LANES_ONE;
    end else if (opc_done) begin
      addr_width <= next_addr_width;
      data_width <= next_data_width;
    end
  end

  // The dword address loads from the byte address and steps after each full word in increment or decrement burst mode.
  always_ff @(posedge i_serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dword <= '0;
      burst <= '0;
    end else if (addr_done) begin
      dword <= next_shift[sqw_pkg::DWORD_MSB:sqw_pkg::DWORD_LSB];
      burst <= next_shift[sqw_pkg::BURST_MSB:sqw_pkg::BURST_LSB];
    end else if (word_done) begin
      dword <= next_dword;
    end
  end

  // ---------------------------------------------------------------
  // Word hand-over to the system clock
  // ---------------------------------------------------------------
  sqw_pkg::wr_req_t held;
  logic held_toggle;

  // Held outside the select reset so a word survives the select release that follows it.
  // It stays stable for at least eight serial clocks, far longer than the crossing takes.
  always_ff @(posedge i_serial_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      held <= '0;
      held_toggle <= 1'b0;
    end else if (word_done) begin
      held.dword_addr <= dword;
      held.data <= byte_swap(next_shift);
      held_toggle <= ~held_toggle;
    end
  end

  logic toggle_sync;
  logic toggle_seen;

  sqw_sync2 u_toggle_sync (
    .i_clk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_level(held_toggle),
    .o_level(toggle_sync)
  );

  wire new_word;
  assign new_word = toggle_sync ^ toggle_seen;

  // A toggle edge marks one finished word; the strobe lasts one system clock.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      toggle_seen <= 1'b0;
      o_wr_strobe <= 1'b0;
      o_wr_dword_addr <= '0;
      o_wr_data <= '0;
    end else begin
      toggle_seen <= toggle_sync;
      o_wr_strobe <= new_word;
      if (new_word) begin
        o_wr_dword_addr <= held.dword_addr;
        o_wr_data <= held.data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame status
  // ---------------------------------------------------------------
  logic select_sync;

  sqw_sync2 u_select_sync (
    .i_clk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_level(~i_serial_select_n),
    .o_level(select_sync)
  );

  assign o_frame_active = select_sync;

  // ---------------------------------------------------------------
  // Status FIFO pop decode
  // ---------------------------------------------------------------

  // Only the normal addresses advance a FIFO; the peek addresses deliberately have no effect here.
  wire rx_pop_hit;
  wire tx_pop_hit;
  assign rx_pop_hit = i_rd_strobe && (i_rd_addr == sqw_pkg::RX_STATUS_ADDR);
  assign tx_pop_hit = i_rd_strobe && (i_rd_addr == sqw_pkg::TX_STATUS_ADDR);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_status_pop <= 1'b0;
      o_tx_status_pop <= 1'b0;
    end else begin
      o_rx_status_pop <= rx_pop_hit;
      o_tx_status_pop <= tx_pop_hit;
    end
  end

endmodule : serial_quad_register_write_slave

`default_nettype wire

// ===== sqw_props.sv
// Concurrent checks on the ports of the serial register write slave.
`default_nettype none

module sqw_props (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Inputs watched
  input wire logic i_serial_select_n,
  input wire logic i_rd_strobe,
  input wire logic [15:0] i_rd_addr,
  // Outputs watched
  input wire logic o_wr_strobe,
  input wire logic [11:0] o_wr_dword_addr,
  input wire logic [31:0] o_wr_data,
  input wire logic o_frame_active,
  input wire logic o_rx_status_pop,
  input wire logic o_tx_status_pop
);
  // ---------------------------------------------------------------
  // System clock assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // A commit must be a single pulse, or one word could land twice.
  chk_strobe_single: assert property (o_wr_strobe |=> !o_wr_strobe)
    else $error("write strobe longer than one cycle");
  chk_data_held: assert property ($changed(o_wr_data) |-> o_wr_strobe)
    else $error("write data moved without a strobe");
  chk_addr_held: assert property ($changed(o_wr_dword_addr) |-> o_wr_strobe)
    else $error("dword address moved without a strobe");
  chk_strobe_in_frame: assert property (o_wr_strobe |-> o_frame_active)
    else $error("write strobe outside a frame");
  chk_frame_seen: assert property ($fell(i_serial_select_n) |-> ##[1:4] o_frame_active)
    else $error("frame not flagged after select fell");
  chk_rx_pop_due: assert property (
    i_rd_strobe && i_rd_addr == sqw_pkg::RX_STATUS_ADDR |=> o_rx_status_pop)
    else $error("receive status read did not pop");
  chk_rx_pop_cause: assert property (
    o_rx_status_pop |-> $past(i_rd_strobe) && $past(i_rd_addr) == sqw_pkg::RX_STATUS_ADDR)
    else $error("receive status pop without a normal read");
  chk_tx_pop_due: assert property (
    i_rd_strobe && i_rd_addr == sqw_pkg::TX_STATUS_ADDR |=> o_tx_status_pop)
    else $error("transmit status read did not pop");
  chk_tx_pop_cause: assert property (
    o_tx_status_pop |-> $past(i_rd_strobe) && $past(i_rd_addr) == sqw_pkg::TX_STATUS_ADDR)
    else $error("transmit status pop without a normal read");
endmodule : sqw_props

bind serial_quad_register_write_slave sqw_props u_props (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_serial_select_n(i_serial_select_n),
  .i_rd_strobe(i_rd_strobe), .i_rd_addr(i_rd_addr), .o_wr_strobe(o_wr_strobe),
  .o_wr_dword_addr(o_wr_dword_addr), .o_wr_data(o_wr_data), .o_frame_active(o_frame_active),
  .o_rx_status_pop(o_rx_status_pop), .o_tx_status_pop(o_tx_status_pop)
);

`default_nettype wire

// ===== sqw_host.sv
// Behavioural host controller that drives the serial link of the write slave.
`default_nettype none

module sqw_host (
  // Link pins toward the slave
  output logic o_sclk,
  output logic o_select_n,
  output logic [3:0] o_lanes
);
  timeunit 1ns;
  timeprecision 100ps;
  // The model only drives the lanes; it never samples returned data, so it needs no read-sample delay.
  localparam realtime HALF = 62.5;

  // Clock stands still low and select stays high outside frames.
  initial begin
    o_sclk = 1'b0;
    o_select_n = 1'b1;
    o_lanes = 4'h5;
  end

  // Lanes change after the falling edge; unused lanes toggle so no stale value lingers.
  task automatic shift(input logic [31:0] v, input int nbits, input int w);
    logic [3:0] t;
    for (int i = nbits - w; i >= 0; i -= w) begin
      t = ~o_lanes;
      for (int b = 0; b < w; b++)
        t[b] = v[i + b];
      o_lanes = t;
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
  endtask : shift

  // One frame: opcode, address, words that differ by index, then a partial word of extra bits.
  task automatic frame(input logic quad, input logic [7:0] opc, input logic [15:0] addr,
                       input logic [31:0] d0, input int nwords, input int extra);
    int ow;
    int aw;
    int dw;
    logic [31:0] w;
    ow = 1;
    aw = 1;
    dw = 1;
    case (opc)
      sqw_pkg::OPC_DUAL_DATA_WRITE: dw = 2;
      sqw_pkg::OPC_QUAD_DATA_WRITE: dw = 4;
      sqw_pkg::OPC_DUAL_ADDR_DATA_WRITE: begin
        aw = 2;
        dw = 2;
      end
      sqw_pkg::OPC_QUAD_ADDR_DATA_WRITE: begin
        aw = 4;
        dw = 4;
      end
      default: dw = 1;
    endcase
    if (quad) begin
      ow = 4;
      aw = 4;
      dw = 4;
    end
    o_select_n = 1'b0;
    shift({24'h0, opc}, 8, ow);
    shift({16'h0, addr}, 16, aw);
    for (int k = 0; k <= nwords; k++) begin
      w = d0 ^ k;
      shift({w[7:0], w[15:8], w[23:16], w[31:24]}, (k < nwords) ? 32 : extra, dw);
    end
    #HALF;
    o_lanes = ~o_lanes;
    o_select_n = 1'b1;
    #(4 * HALF);
  endtask : frame
endmodule : sqw_host

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the serial register write slave.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Signals, rows and bookkeeping
  // ---------------------------------------------------------------
  typedef struct packed {
    logic quad;
    logic [7:0] opc;
    logic [15:0] addr;
    logic [31:0] data;
    logic [7:0] extra;
    logic [1:0] nexp;
    logic [11:0] a0;
    logic [11:0] step;
  } row_t;
  // Each row sends two words plus a partial one of extra bits when extra is non-zero; refused rows expect no commit.
  const row_t rows [11] = '{
    {1'b0, 8'h02, 16'h4008, 32'h11223344, 8'h10, 2'h2, 12'h002, 12'h001},
    {1'b0, 8'h32, 16'h8010, 32'ha5c30f96, 8'h1e, 2'h2, 12'h004, 12'hfff},
    {1'b0, 8'h62, 16'h0021, 32'h0badf00d, 8'h1c, 2'h2, 12'h008, 12'h000},
    {1'b0, 8'hb2, 16'h7ffc, 32'h89abcdef, 8'h00, 2'h2, 12'hfff, 12'h001},
    {1'b0, 8'he2, 16'h8000, 32'h13579bdf, 8'h04, 2'h2, 12'h000, 12'hfff},
    {1'b0, 8'hff, 16'h4000, 32'h12345678, 8'h00, 2'h0, 12'h000, 12'h000},
    {1'b1, 8'h02, 16'h400c, 32'hcafe1234, 8'h18, 2'h2, 12'h003, 12'h001},
    {1'b1, 8'h32, 16'h4000, 32'h00000001, 8'h00, 2'h0, 12'h000, 12'h000},
    {1'b1, 8'h62, 16'h4000, 32'h00000002, 8'h00, 2'h0, 12'h000, 12'h000},
    {1'b1, 8'hb2, 16'h4000, 32'h00000003, 8'h00, 2'h0, 12'h000, 12'h000},
    {1'b1, 8'he2, 16'h4000, 32'h00000004, 8'h00, 2'h0, 12'h000, 12'h000}};
  logic i_mclk = 1'b0;
  logic i_arst_n;
  logic mode;
  logic i_rd_strobe;
  logic [15:0] i_rd_addr;
  wire logic sclk;
  wire logic select_n;
  wire logic [3:0] lanes;
  wire logic o_wr_strobe;
  wire logic [11:0] o_wr_dword_addr;
  wire logic [31:0] o_wr_data;
  wire logic o_frame_active;
  wire logic o_rx_status_pop;
  wire logic o_tx_status_pop;
  logic [43:0] seen [$];
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 i_mclk = ~i_mclk;

  sqw_host u_host (.o_sclk(sclk), .o_select_n(select_n), .o_lanes(lanes));

  serial_quad_register_write_slave u_dut (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_serial_clk(sclk), .i_serial_select_n(select_n),
    .i_serial_lanes(lanes), .i_quad_lane_protocol(mode), .o_wr_strobe(o_wr_strobe),
    .o_wr_dword_addr(o_wr_dword_addr), .o_wr_data(o_wr_data), .o_frame_active(o_frame_active),
    .i_rd_strobe(i_rd_strobe), .i_rd_addr(i_rd_addr), .o_rx_status_pop(o_rx_status_pop),
    .o_tx_status_pop(o_tx_status_pop));

  // Commits are logged as they happen so a burst is never missed while the host runs.
  // Sampling on the falling edge reads the registered outputs where they have settled.
  always @(negedge i_mclk) begin
    cycles++;
    if (o_wr_strobe === 1'b1)
      seen.push_back({o_wr_dword_addr, o_wr_data});
    if (cycles == 80000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    i_arst_n = 1'b0;
    mode = 1'b0;
    i_rd_strobe = 1'b0;
    i_rd_addr = 16'h0000;
    repeat (10) @(posedge i_mclk);
    #1 i_arst_n = 1'b1;
    // A mode change is followed by a throwaway frame so the mode settles in the link domain.
    for (int r = 0; r < 11; r++) begin
      if (rows[r].quad !== mode) begin
        @(posedge i_mclk);
        #1 mode = rows[r].quad;
        u_host.frame(mode, 8'h00, 16'h0000, 32'h0, 0, 0);
      end
      seen.delete();
      u_host.frame(rows[r].quad, rows[r].opc, rows[r].addr, rows[r].data, 2, rows[r].extra);
      check("commit count", seen.size(), rows[r].nexp);
      for (int k = 0; k < rows[r].nexp; k++)
        check("commit", seen[k], {12'(rows[r].a0 + rows[r].step * k), rows[r].data ^ k});
    end
    // Back-to-back status reads across normal and peek addresses.
    @(posedge i_mclk);
    #1 i_rd_strobe = 1'b1;
    for (int a = 0; a < 5; a++) begin
      i_rd_addr = 16'h0040 + 16'(4 * a);
      @(posedge i_mclk);
      #1 check("status pops", {o_rx_status_pop, o_tx_status_pop}, {a == 0, a == 2});
    end
    i_rd_strobe = 1'b0;
    // A reset in mid-run clears the write strobe, address, data and frame-active outputs.
    @(posedge i_mclk);
    #1 i_arst_n = 1'b0;
    #1 check("reset outputs", {o_wr_strobe, o_wr_dword_addr, o_wr_data, o_frame_active}, 48'h0);
    // Release again; with no frame running nothing may stir in the first two cycles.
    repeat (2) @(posedge i_mclk);
    #1 i_arst_n = 1'b1;
    repeat (2) begin
      @(posedge i_mclk);
      #1 check("outputs after release", {o_wr_strobe, o_wr_dword_addr, o_wr_data, o_frame_active,
                                         o_rx_status_pop, o_tx_status_pop}, 48'h0);
    end
    final_report();
  end
endmodule : tb_top

`default_nettype wire
